// >>> logic/mht_pkg.sv
// Constants, register map and carrier types of the measurement hold and trigger block.
package mht_pkg;

  localparam int DW = 32;
  localparam int SUM_W = 48;
  localparam int CNT_W = 16;
  localparam int PROC_W = 14;

  typedef enum logic [2:0] {
    MD_NORMAL,
    MD_PEAK,
    MD_BOTTOM,
    MD_P2P,
    MD_SAMPLE,
    MD_AVERAGE
  } mht_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLING,
    ST_RESETTING
  } mht_state_t;

  typedef struct packed {
    logic auto_tx;
    logic trig2;
    mht_mode_t mode;
  } mht_cfg_t;

  localparam int CFG_W = $bits(mht_cfg_t);

  typedef struct packed {
    logic standby;
    logic [DW-1:0] value;
  } mht_result_t;

  // Register byte offsets.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PROC = 6'h04;
  localparam logic [5:0] OFS_AVG = 6'h08;
  localparam logic [5:0] OFS_CMD = 6'h0c;
  localparam logic [5:0] OFS_RESULT = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_HI_LIM = 6'h18;
  localparam logic [5:0] OFS_LO_LIM = 6'h1c;

  // Command register bits.
  localparam int CMD_SYNC_BIT = 0;
  localparam int CMD_RESET_BIT = 1;
  localparam int CMD_ZERO_BIT = 2;
  localparam int CMD_PROG_BIT = 3;

  // Status register bits.
  localparam int STAT_STANDBY_BIT = 0;
  localparam int STAT_SAMPLING_BIT = 1;
  localparam int STAT_ALARM_BIT = 2;
  localparam int STAT_RESETTING_BIT = 3;

  // Reset values and fixed codes.
  localparam mht_cfg_t CFG_RST = '{auto_tx: 1'b0, trig2: 1'b0, mode: MD_NORMAL};
  localparam logic [PROC_W-1:0] PROC_HOLD_LAST = 14'h270f;
  localparam logic [PROC_W-1:0] PROC_RST = 14'h270f;
  localparam logic [CNT_W-1:0] AVG_RST = 16'h0001;
  localparam logic [DW-1:0] HI_LIM_RST = 32'h7fffffff;
  localparam logic [DW-1:0] LO_LIM_RST = 32'h80000000;
  localparam logic [DW-1:0] ALARM_CODE = 32'hff000001;
  localparam logic [CNT_W-1:0] RESET_OP_SAMPLES = 16'h0004;

endpackage

// >>> logic/mht_sync_edge.sv
// Two-stage synchroniser with edge detection for one external input.
`timescale 1ns/1ps
`default_nettype none
module mht_sync_edge #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw input
  input wire logic din,
  // Synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_ff, s2_ff, prev_ff;
  logic nxt_s1, nxt_s2, nxt_prev;

  always_comb begin
    nxt_s1 = din;
    nxt_s2 = s1_ff;
    nxt_prev = s2_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      prev_ff <= INIT;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      prev_ff <= nxt_prev;
    end
  end

  // Only the second stage and its delayed copy feed the edge logic.
  assign level = s2_ff;
  assign rise = s2_ff & ~prev_ff;
  assign fall = ~s2_ff & prev_ff;

endmodule
`default_nettype wire

// >>> logic/mht_top.sv
// Hold, trigger, comparator and serial timing logic with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sample hold, trigger 1: hold the measured value seen at sync turn-on.
// - Stay in comparator standby after restart events until a new value exists.
// - Comparator outputs follow the current held value.
// - With automatic transmission on, send a result on each rising edge of the timing input.
// - Process count 9999: alarms keep the last held value as result.
// - Count 0 to 9998: alarm longer than count gives alarm code result.
// - Sample hold, trigger 2: hold average of configured samples after sync on.
// - Sample hold, trigger 2: sync turn-on aborts a reset and starts sampling.
// - Sample hold, trigger 2: reset or zero while sampling stops it, standby.
// - Software commands act as sync and reset inputs like the pins.
// - Trigger 1 hold modes: sampling period runs sync rise to next rise.
// - Trigger 2 hold modes: sampling period runs sync fall to next rise.
// - Normal mode, trigger 2: latch value at sync rise, keep while on.
// - Trigger 1 hold modes: sync turn-on does not clear the held value.
// - Trigger 2 hold modes: sync turn-off clears the internal accumulation.
module mht_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measured value stream
  input wire logic meas_valid,
  input wire logic [31:0] meas_value,
  input wire logic meas_alarm,
  // External control pins
  input wire logic sync_pin,
  input wire logic reset_pin,
  input wire logic zero_pin,
  input wire logic first_timing_input,
  // Result and comparator
  output mht_pkg::mht_result_t result,
  output logic cmp_hi,
  output logic cmp_go,
  output logic cmp_lo,
  // Serial result hand-off
  output logic tx_valid,
  output mht_pkg::mht_result_t tx_data
);

  ////////////////////////////////////////////////////////////////////////////////
  logic sync_lvl_pin, rst_rise, zero_rise, t1_rise;

  mht_sync_edge u_sync (.mclk(mclk), .rst_n(rst_n), .din(sync_pin), .level(sync_lvl_pin), .rise(), .fall());
  mht_sync_edge u_rst (.mclk(mclk), .rst_n(rst_n), .din(reset_pin), .level(), .rise(rst_rise), .fall());
  mht_sync_edge u_zero (.mclk(mclk), .rst_n(rst_n), .din(zero_pin), .level(), .rise(zero_rise), .fall());
  mht_sync_edge u_t1 (.mclk(mclk), .rst_n(rst_n), .din(first_timing_input), .level(), .rise(t1_rise), .fall());

  ////////////////////////////////////////////////////////////////////////////////
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  mht_pkg::mht_cfg_t cfg_ff, nxt_cfg;
  logic [mht_pkg::PROC_W-1:0] proc_ff, nxt_proc;
  logic [mht_pkg::CNT_W-1:0] avg_ff, nxt_avg;
  logic [31:0] hi_ff, nxt_hi, lo_ff, nxt_lo;
  logic sw_sync_ff, nxt_sw_sync;
  logic wr_go, rd_go, cfg_wr, sw_rst, sw_zero, sw_prog;
  logic [31:0] wmask, cmd_img;
  mht_pkg::mht_state_t st_ff, nxt_st;
  logic standby_ff, nxt_standby;
  logic [31:0] held_ff, nxt_held;
  logic alhit_ff, nxt_alhit;

  assign wr_go = avs_write & ack_ff;
  assign rd_go = avs_read & ~ack_ff;
  // One wait state keeps the read path registered at the cost of a cycle per access.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cmd_img = avs_writedata & wmask;
  assign cfg_wr = wr_go && (avs_address == mht_pkg::OFS_CTRL);
  assign sw_rst = wr_go && (avs_address == mht_pkg::OFS_CMD) && cmd_img[mht_pkg::CMD_RESET_BIT];
  assign sw_zero = wr_go && (avs_address == mht_pkg::OFS_CMD) && cmd_img[mht_pkg::CMD_ZERO_BIT];
  assign sw_prog = wr_go && (avs_address == mht_pkg::OFS_CMD) && cmd_img[mht_pkg::CMD_PROG_BIT];

  always_comb begin
    logic [31:0] merged;
    merged = '0;
    nxt_ack = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_cfg = cfg_ff;
    nxt_proc = proc_ff;
    nxt_avg = avg_ff;
    nxt_hi = hi_ff;
    nxt_lo = lo_ff;
    nxt_sw_sync = sw_sync_ff;
    if (rd_go) begin
      if (avs_address == mht_pkg::OFS_CTRL) begin
        nxt_rdata = {{(32 - mht_pkg::CFG_W){1'b0}}, cfg_ff};
      end else if (avs_address == mht_pkg::OFS_PROC) begin
        nxt_rdata = {{(32 - mht_pkg::PROC_W){1'b0}}, proc_ff};
      end else if (avs_address == mht_pkg::OFS_AVG) begin
        nxt_rdata = {{(32 - mht_pkg::CNT_W){1'b0}}, avg_ff};
      end else if (avs_address == mht_pkg::OFS_CMD) begin
        nxt_rdata = '0;
        nxt_rdata[mht_pkg::CMD_SYNC_BIT] = sw_sync_ff;
      end else if (avs_address == mht_pkg::OFS_RESULT) begin
        nxt_rdata = held_ff;
      end else if (avs_address == mht_pkg::OFS_STATUS) begin
        nxt_rdata = '0;
        nxt_rdata[mht_pkg::STAT_STANDBY_BIT] = standby_ff;
        nxt_rdata[mht_pkg::STAT_SAMPLING_BIT] = (st_ff == mht_pkg::ST_SAMPLING);
        nxt_rdata[mht_pkg::STAT_ALARM_BIT] = alhit_ff;
        nxt_rdata[mht_pkg::STAT_RESETTING_BIT] = (st_ff == mht_pkg::ST_RESETTING);
      end else if (avs_address == mht_pkg::OFS_HI_LIM) begin
        nxt_rdata = hi_ff;
      end else if (avs_address == mht_pkg::OFS_LO_LIM) begin
        nxt_rdata = lo_ff;
      end else begin
        nxt_rdata = '0;
      end
    end
    if (wr_go) begin
      if (avs_address == mht_pkg::OFS_CTRL) begin
        merged = ({{(32 - mht_pkg::CFG_W){1'b0}}, cfg_ff} & ~wmask) | cmd_img;
        nxt_cfg = mht_pkg::mht_cfg_t'(merged[mht_pkg::CFG_W-1:0]);
      end else if (avs_address == mht_pkg::OFS_PROC) begin
        merged = ({{(32 - mht_pkg::PROC_W){1'b0}}, proc_ff} & ~wmask) | cmd_img;
        nxt_proc = merged[mht_pkg::PROC_W-1:0];
      end else if (avs_address == mht_pkg::OFS_AVG) begin
        merged = ({{(32 - mht_pkg::CNT_W){1'b0}}, avg_ff} & ~wmask) | cmd_img;
        nxt_avg = merged[mht_pkg::CNT_W-1:0];
      end else if (avs_address == mht_pkg::OFS_CMD) begin
        if (avs_byteenable[0]) begin
          nxt_sw_sync = cmd_img[mht_pkg::CMD_SYNC_BIT];
        end
      end else if (avs_address == mht_pkg::OFS_HI_LIM) begin
        nxt_hi = (hi_ff & ~wmask) | cmd_img;
      end else if (avs_address == mht_pkg::OFS_LO_LIM) begin
        nxt_lo = (lo_ff & ~wmask) | cmd_img;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      cfg_ff <= mht_pkg::CFG_RST;
      proc_ff <= mht_pkg::PROC_RST;
      avg_ff <= mht_pkg::AVG_RST;
      hi_ff <= mht_pkg::HI_LIM_RST;
      lo_ff <= mht_pkg::LO_LIM_RST;
      sw_sync_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      cfg_ff <= nxt_cfg;
      proc_ff <= nxt_proc;
      avg_ff <= nxt_avg;
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
      sw_sync_ff <= nxt_sw_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic sync_lvl, sync_prev_ff, sync_rise, sync_fall, restart, accum_mode;
  logic signed [31:0] max_ff, nxt_max, min_ff, nxt_min;
  logic signed [mht_pkg::SUM_W-1:0] sum_ff, nxt_sum, avg_q;
  logic [mht_pkg::CNT_W-1:0] cnt_ff, nxt_cnt, rstcnt_ff, nxt_rstcnt, avg_eff;
  logic [mht_pkg::PROC_W-1:0] alrun_ff, nxt_alrun;
  logic [31:0] last_ff, nxt_last;
  logic last_ok_ff, nxt_last_ok;

  // The software sync level is ORed in before edge detection, so it acts exactly like the pin.
  assign sync_lvl = sync_lvl_pin | sw_sync_ff;
  assign sync_rise = sync_lvl & ~sync_prev_ff;
  assign sync_fall = ~sync_lvl & sync_prev_ff;
  assign restart = rst_rise | sw_rst | zero_rise | sw_zero | cfg_wr | sw_prog;
  assign accum_mode = (cfg_ff.mode == mht_pkg::MD_PEAK) || (cfg_ff.mode == mht_pkg::MD_BOTTOM) ||
                      (cfg_ff.mode == mht_pkg::MD_P2P) || (cfg_ff.mode == mht_pkg::MD_AVERAGE);
  assign avg_eff = (avg_ff == '0) ? mht_pkg::AVG_RST : avg_ff;
  // A full divider keeps the average exact; it is the widest path in the block.
  assign avg_q = sum_ff / $signed({{(mht_pkg::SUM_W - mht_pkg::CNT_W){1'b0}}, ((cnt_ff == '0) ? mht_pkg::AVG_RST : cnt_ff)});

  always_comb begin
    logic [31:0] cls_val;
    logic cls_ok, clr;
    cls_val = held_ff;
    cls_ok = 1'b0;
    clr = 1'b0;
    nxt_st = st_ff;
    nxt_standby = standby_ff;
    nxt_held = held_ff;
    nxt_max = max_ff;
    nxt_min = min_ff;
    nxt_sum = sum_ff;
    nxt_cnt = cnt_ff;
    nxt_alrun = alrun_ff;
    nxt_alhit = alhit_ff;
    nxt_last = last_ff;
    nxt_last_ok = last_ok_ff;
    nxt_rstcnt = rstcnt_ff;
    // Result of a closing sampling period; an empty period keeps the old value.
    if (alhit_ff) begin
      cls_val = mht_pkg::ALARM_CODE;
      cls_ok = 1'b1;
    end else if (cnt_ff != '0) begin
      cls_ok = 1'b1;
      case (cfg_ff.mode)
        mht_pkg::MD_PEAK: cls_val = max_ff;
        mht_pkg::MD_BOTTOM: cls_val = min_ff;
        mht_pkg::MD_P2P: cls_val = max_ff - min_ff;
        default: cls_val = avg_q[31:0];
      endcase
    end
    // Alarmed samples never enter the accumulation, so the last good value survives.
    if (meas_valid && (st_ff == mht_pkg::ST_SAMPLING)) begin
      if (meas_alarm) begin
        if (alrun_ff != '1) begin
          nxt_alrun = alrun_ff + 1'b1;
        end
        if ((proc_ff != mht_pkg::PROC_HOLD_LAST) && (alrun_ff >= proc_ff)) begin
          nxt_alhit = 1'b1;
        end
      end else begin
        nxt_alrun = '0;
        nxt_last = meas_value;
        nxt_last_ok = 1'b1;
        nxt_max = ((cnt_ff == '0) || ($signed(meas_value) > max_ff)) ? $signed(meas_value) : max_ff;
        nxt_min = ((cnt_ff == '0) || ($signed(meas_value) < min_ff)) ? $signed(meas_value) : min_ff;
        nxt_sum = sum_ff + {{(mht_pkg::SUM_W - 32){meas_value[31]}}, meas_value};
        if (cnt_ff != '1) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    end
    if (st_ff == mht_pkg::ST_RESETTING) begin
      if (meas_valid && (rstcnt_ff != '0)) begin
        nxt_rstcnt = rstcnt_ff - 1'b1;
      end
      if (rstcnt_ff == '0) begin
        clr = 1'b1;
        if (cfg_ff.mode == mht_pkg::MD_SAMPLE && cfg_ff.trig2) begin
          nxt_st = mht_pkg::ST_IDLE;
        end else if (accum_mode && cfg_ff.trig2 && sync_lvl) begin
          nxt_st = mht_pkg::ST_IDLE;
        end else begin
          nxt_st = mht_pkg::ST_SAMPLING;
        end
      end
    end
    case (cfg_ff.mode)
      mht_pkg::MD_PEAK, mht_pkg::MD_BOTTOM, mht_pkg::MD_P2P, mht_pkg::MD_AVERAGE: begin
        if (st_ff != mht_pkg::ST_RESETTING) begin
          if (!cfg_ff.trig2 && sync_rise) begin
            if (cls_ok) begin
              nxt_held = cls_val;
              nxt_standby = 1'b0;
            end
            clr = 1'b1;
            nxt_st = mht_pkg::ST_SAMPLING;
          end else if (cfg_ff.trig2 && sync_fall) begin
            clr = 1'b1;
            nxt_st = mht_pkg::ST_SAMPLING;
          end else if (cfg_ff.trig2 && sync_rise && (st_ff == mht_pkg::ST_SAMPLING)) begin
            if (cls_ok) begin
              nxt_held = cls_val;
              nxt_standby = 1'b0;
            end
            nxt_st = mht_pkg::ST_IDLE;
          end
        end
      end
      mht_pkg::MD_SAMPLE: begin
        if (!cfg_ff.trig2) begin
          if (sync_rise && (st_ff == mht_pkg::ST_SAMPLING)) begin
            if (alhit_ff) begin
              nxt_held = mht_pkg::ALARM_CODE;
              nxt_standby = 1'b0;
            end else if (last_ok_ff) begin
              nxt_held = last_ff;
              nxt_standby = 1'b0;
            end
            nxt_alrun = '0;
            nxt_alhit = 1'b0;
          end
        end else begin
          if (sync_rise) begin
            clr = 1'b1;
            nxt_rstcnt = '0;
            nxt_st = mht_pkg::ST_SAMPLING;
          end else if ((st_ff == mht_pkg::ST_SAMPLING) && (alhit_ff || (cnt_ff >= avg_eff))) begin
            nxt_held = alhit_ff ? mht_pkg::ALARM_CODE : avg_q[31:0];
            nxt_standby = 1'b0;
            nxt_st = mht_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        if (st_ff != mht_pkg::ST_RESETTING) begin
          nxt_st = mht_pkg::ST_SAMPLING;
          if (cfg_ff.trig2 && sync_rise && last_ok_ff) begin
            nxt_held = last_ff;
            nxt_standby = 1'b0;
          end else if (meas_valid && !(cfg_ff.trig2 && sync_lvl) && (st_ff == mht_pkg::ST_SAMPLING)) begin
            if (!meas_alarm) begin
              nxt_held = meas_value;
              nxt_alhit = 1'b0;
              nxt_standby = 1'b0;
            end else if (nxt_alhit) begin
              nxt_held = mht_pkg::ALARM_CODE;
              nxt_standby = 1'b0;
            end
          end
        end
      end
    endcase
    if (clr) begin
      nxt_cnt = '0;
      nxt_sum = '0;
      nxt_alrun = '0;
      nxt_alhit = 1'b0;
    end
    // A restart wins over the state, standby, count, sum and alarm updates, including a sampling period in progress.
    if (restart) begin
      nxt_st = mht_pkg::ST_RESETTING;
      nxt_rstcnt = mht_pkg::RESET_OP_SAMPLES;
      nxt_standby = 1'b1;
      nxt_last_ok = 1'b0;
      nxt_cnt = '0;
      nxt_sum = '0;
      nxt_alrun = '0;
      nxt_alhit = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_ff <= 1'b0;
      st_ff <= mht_pkg::ST_SAMPLING;
      standby_ff <= 1'b1;
      held_ff <= '0;
      max_ff <= '0;
      min_ff <= '0;
      sum_ff <= '0;
      cnt_ff <= '0;
      alrun_ff <= '0;
      alhit_ff <= 1'b0;
      last_ff <= '0;
      last_ok_ff <= 1'b0;
      rstcnt_ff <= '0;
    end else begin
      sync_prev_ff <= sync_lvl;
      st_ff <= nxt_st;
      standby_ff <= nxt_standby;
      held_ff <= nxt_held;
      max_ff <= nxt_max;
      min_ff <= nxt_min;
      sum_ff <= nxt_sum;
      cnt_ff <= nxt_cnt;
      alrun_ff <= nxt_alrun;
      alhit_ff <= nxt_alhit;
      last_ff <= nxt_last;
      last_ok_ff <= nxt_last_ok;
      rstcnt_ff <= nxt_rstcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic hi_q_ff, go_q_ff, lo_q_ff, nxt_hi_q, nxt_go_q, nxt_lo_q, tx_v_ff, nxt_tx_v;
  mht_pkg::mht_result_t tx_ff, nxt_tx;

  always_comb begin
    // Standby forces all judgements off so nothing downstream acts on a stale value.
    nxt_hi_q = !standby_ff && ($signed(held_ff) > $signed(hi_ff));
    nxt_lo_q = !standby_ff && ($signed(held_ff) < $signed(lo_ff));
    nxt_go_q = !standby_ff && !nxt_hi_q && !nxt_lo_q;
    nxt_tx_v = t1_rise && cfg_ff.auto_tx;
    nxt_tx = nxt_tx_v ? mht_pkg::mht_result_t'{standby: standby_ff, value: held_ff} : tx_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q_ff <= 1'b0;
      go_q_ff <= 1'b0;
      lo_q_ff <= 1'b0;
      tx_v_ff <= 1'b0;
      tx_ff <= '0;
    end else begin
      hi_q_ff <= nxt_hi_q;
      go_q_ff <= nxt_go_q;
      lo_q_ff <= nxt_lo_q;
      tx_v_ff <= nxt_tx_v;
      tx_ff <= nxt_tx;
    end
  end

  assign result = '{standby: standby_ff, value: held_ff};
  assign cmp_hi = hi_q_ff;
  assign cmp_go = go_q_ff;
  assign cmp_lo = lo_q_ff;
  assign tx_valid = tx_v_ff;
  assign tx_data = tx_ff;

endmodule
`default_nettype wire

// >>> sim/mht_top_asserts.sv
// Port checker for the measurement hold and trigger block.
`timescale 1ns/1ps
`default_nettype none
module mht_top_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // Pins
  input wire logic reset_pin,
  input wire logic zero_pin,
  input wire logic first_timing_input,
  // Results
  input wire mht_pkg::mht_result_t result,
  input wire logic cmp_hi,
  input wire logic cmp_go,
  input wire logic cmp_lo,
  input wire logic tx_valid,
  input wire mht_pkg::mht_result_t tx_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_cmp_standby: assert property (result.standby |=> !(cmp_hi || cmp_go || cmp_lo))
    else $error("comparator active in standby");
  a_cmp_onehot: assert property (!$past(result.standby) |-> $onehot({cmp_hi, cmp_go, cmp_lo}))
    else $error("comparator outputs not one-hot");
  a_tx_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("transmit strobe longer than one cycle");
  a_tx_stable: assert property (!tx_valid |-> $stable(tx_data))
    else $error("transmit data moved without strobe");
  a_tx_timing: assert property ($rose(tx_valid) |-> $past(first_timing_input, 2))
    else $error("transmit without timing input");
  a_reset_standby: assert property ($rose(reset_pin) |-> ##[2:5] result.standby)
    else $error("reset pin did not enter standby");
  a_zero_standby: assert property ($rose(zero_pin) |-> ##[2:5] result.standby)
    else $error("zero pin did not enter standby");
endmodule
bind mht_top mht_top_chk u_chk (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .reset_pin(reset_pin), .zero_pin(zero_pin),
  .first_timing_input(first_timing_input), .result(result), .cmp_hi(cmp_hi), .cmp_go(cmp_go),
  .cmp_lo(cmp_lo), .tx_valid(tx_valid), .tx_data(tx_data));
`default_nettype wire

// >>> sim/mht_ctrl_model.sv
// External controller model: control pins and the measured sample stream.
`timescale 1ns/1ps
`default_nettype none
module mht_ctrl_model (
  // Clock
  input wire logic mclk,
  // Control pins
  output logic sync_pin,
  output logic reset_pin,
  output logic zero_pin,
  output logic first_timing_input,
  // Sample stream
  output logic meas_valid,
  output logic [31:0] meas_value,
  output logic meas_alarm
);
  initial begin
    {sync_pin, reset_pin, zero_pin, first_timing_input, meas_valid, meas_alarm} = 6'h00;
    meas_value = 32'h0;
  end
  // Outside the strobe the value is inverted so a stale value is never mistaken for a sample.
  task automatic smp(input logic [31:0] v, input logic a);
    @(posedge mclk);
    meas_valid <= 1'b1;
    meas_value <= v;
    meas_alarm <= a;
    @(posedge mclk);
    meas_valid <= 1'b0;
    meas_value <= ~v;
    meas_alarm <= ~a;
    repeat (3) @(posedge mclk);
  endtask
  // Levels are held long enough to pass the synchroniser and edge stage.
  task automatic lvl(input int w, input logic l);
    @(posedge mclk);
    case (w)
      0: sync_pin <= l;
      1: reset_pin <= l;
      2: zero_pin <= l;
      default: first_timing_input <= l;
    endcase
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> sim/mht_top_test.sv
// Self-checking testbench of the measurement hold and trigger block.
`timescale 1ns/1ps
`default_nettype none
module mht_top_test;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, tx_valid, cmp_hi, cmp_go, cmp_lo;
  logic meas_valid, meas_alarm, sync_pin, reset_pin, zero_pin, first_timing_input;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, meas_value, q;
  mht_pkg::mht_result_t result, tx_data;
  int mismatches = 0;
  int num_checks = 0;
  mht_top dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_alarm(meas_alarm), .sync_pin(sync_pin), .reset_pin(reset_pin), .zero_pin(zero_pin),
    .first_timing_input(first_timing_input), .result(result), .cmp_hi(cmp_hi), .cmp_go(cmp_go),
    .cmp_lo(cmp_lo), .tx_valid(tx_valid), .tx_data(tx_data));
  mht_ctrl_model ctl (.mclk(mclk), .sync_pin(sync_pin), .reset_pin(reset_pin), .zero_pin(zero_pin),
    .first_timing_input(first_timing_input), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_alarm(meas_alarm));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic see(input logic [31:0] v, input logic s);
    @(negedge mclk);
    chk(result.value, v);
    chk(32'(result.standby), 32'(s));
  endtask
  // The slave's wait count is not assumed; only the loop bound ends a stuck wait.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] c);
    bus(1'b1, mht_pkg::OFS_CTRL, c);
    repeat (5) ctl.smp(32'h0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [5:0] ofs [6] = '{6'h00, 6'h04, 6'h08, 6'h18, 6'h1c, 6'h20};
    logic [31:0] exp [6] = '{32'h0, 32'h270f, 32'h1, 32'h7fffffff, 32'h80000000, 32'h0};
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk(q, exp[i]);
    end
    bus(1'b1, mht_pkg::OFS_RESULT, 32'h1234);
    bus(1'b0, mht_pkg::OFS_RESULT, 32'h0);
    chk(q, 32'h0);
    see(32'h0, 1'b1);
    ctl.smp(32'h10, 1'b0);
    see(32'h10, 1'b0);
    @(negedge mclk);
    chk(32'(cmp_go), 32'h1);
    bus(1'b1, mht_pkg::OFS_HI_LIM, 32'h8);
    repeat (2) @(negedge mclk);
    chk(32'(cmp_hi), 32'h1);
    $display("test registers and normal done");
  endtask
  task automatic t_alarm();
    bus(1'b1, mht_pkg::OFS_PROC, 32'h1);
    ctl.smp(32'h20, 1'b0);
    ctl.smp(32'h0, 1'b1);
    ctl.smp(32'h0, 1'b1);
    see(32'hff000001, 1'b0);
    bus(1'b1, mht_pkg::OFS_PROC, 32'h270f);
    ctl.smp(32'h30, 1'b0);
    repeat (3) ctl.smp(32'h0, 1'b1);
    see(32'h30, 1'b0);
    $display("test alarm done");
  endtask
  task automatic t_tx();
    int n;
    n = 0;
    cfg(32'h10);
    ctl.smp(32'h40, 1'b0);
    fork
      ctl.lvl(3, 1'b1);
      do begin
        @(negedge mclk);
        n++;
      end while (tx_valid !== 1'b1 && n < 20);
    join
    chk(32'(n < 20), 32'h1);
    chk(tx_data.value, 32'h40);
    ctl.lvl(3, 1'b0);
    $display("test transmit done");
  endtask
  task automatic t_trig1();
    cfg(32'h4);
    ctl.smp(32'h50, 1'b0);
    ctl.lvl(0, 1'b1);
    ctl.smp(32'h60, 1'b0);
    see(32'h50, 1'b0);
    ctl.lvl(0, 1'b0);
    cfg(32'h1);
    ctl.lvl(0, 1'b1);
    ctl.lvl(0, 1'b0);
    ctl.smp(32'h5, 1'b0);
    ctl.smp(32'h9, 1'b0);
    ctl.smp(32'h3, 1'b0);
    ctl.lvl(0, 1'b1);
    see(32'h9, 1'b0);
    ctl.lvl(0, 1'b0);
    ctl.smp(32'h4, 1'b0);
    ctl.lvl(0, 1'b1);
    see(32'h4, 1'b0);
    ctl.lvl(0, 1'b0);
    $display("test trigger one done");
  endtask
  task automatic t_trig2();
    cfg(32'h9);
    ctl.lvl(0, 1'b1);
    ctl.smp(32'h7, 1'b0);
    ctl.lvl(0, 1'b0);
    ctl.smp(32'h2, 1'b0);
    ctl.smp(32'h3, 1'b0);
    ctl.lvl(0, 1'b1);
    see(32'h3, 1'b0);
    ctl.lvl(0, 1'b0);
    cfg(32'h8);
    ctl.smp(32'h11, 1'b0);
    ctl.lvl(0, 1'b1);
    ctl.smp(32'h12, 1'b0);
    see(32'h11, 1'b0);
    ctl.lvl(0, 1'b0);
    bus(1'b1, mht_pkg::OFS_AVG, 32'h2);
    bus(1'b1, mht_pkg::OFS_CTRL, 32'hc);
    ctl.lvl(0, 1'b1);
    ctl.smp(32'h10, 1'b0);
    ctl.smp(32'h20, 1'b0);
    see(32'h18, 1'b0);
    ctl.lvl(0, 1'b0);
    ctl.lvl(0, 1'b1);
    ctl.smp(32'h30, 1'b0);
    ctl.lvl(1, 1'b1);
    see(32'h18, 1'b1);
    ctl.lvl(1, 1'b0);
    ctl.lvl(0, 1'b0);
    $display("test trigger two done");
  endtask
  task automatic t_cmd();
    cfg(32'h0);
    ctl.smp(32'h70, 1'b0);
    bus(1'b1, mht_pkg::OFS_CMD, 32'h2);
    repeat (2) @(negedge mclk);
    chk(32'(result.standby), 32'h1);
    cfg(32'h4);
    ctl.smp(32'h80, 1'b0);
    bus(1'b1, mht_pkg::OFS_CMD, 32'h1);
    repeat (6) @(posedge mclk);
    see(32'h80, 1'b0);
    bus(1'b1, mht_pkg::OFS_CMD, 32'h0);
    ctl.lvl(2, 1'b1);
    see(32'h80, 1'b1);
    ctl.lvl(2, 1'b0);
    $display("test commands done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_alarm();
    t_tx();
    t_trig1();
    t_trig2();
    t_cmd();
    give_verdict();
  end
  // The whole sequence needs well under a thousand cycles; this bound leaves ample margin.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
